// *** pkg/tmc_map.vh ***
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TMC_ADDR_W 16
`define TMC_OFF_REVISION 16'h0400
`define TMC_OFF_SCRATCH 16'h0401
`define TMC_OFF_IDENT_FIRST 16'h0402
`define TMC_OFF_IDENT_NEXT 16'h0403
`define TMC_OFF_IDENT_FINAL 16'h0404
`define TMC_OFF_LINK_FAULT 16'h0405
`define TMC_OFF_IDLE_REMOVE 16'h0406
`define TMC_OFF_FRAME_LIMIT 16'h0407
`define TMC_OFF_OVERSIZE_LO 16'h0408
`define TMC_OFF_OVERSIZE_HI 16'h0409
// ---------------------------------------------------------------
// Reset values and fields
// ---------------------------------------------------------------
`define TMC_SCRATCH_RST 32'h00000000
`define TMC_IDLE_RST_100G 8'h14
`define TMC_IDLE_RST_40G 8'h04
`define TMC_FRAME_LIMIT_RST 16'h2580
`define TMC_IDLE_W 8
`define TMC_FRAME_W 16
`define TMC_LINK_FAULT_W 4
`endif

// *** src/tmc_tx_mac_config_regs.v ***
`timescale 1ns/10ps
`include "tmc_map.vh"

module tmc_tx_mac_config_regs #(
    parameter IS_100G = 1,
    parameter DEFICIT_IDLE_EN = 1,
    parameter TX_STATS_EN = 1,
    parameter LINK_FAULT_EN = 1,
    // Arbitrary revision value
    parameter [31:0] REVISION_VALUE = 32'h00010000,
    // Arbitrary identifier characters
    parameter [95:0] IDENT_VALUE = 96'h746D635F74785F6373720000
) (
    input wire mclk,
    input wire reset_n,
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    input wire frame_done,
    input wire [15:0] frame_len,
    output reg [7:0] idle_column_removal_count,
    output reg [15:0] tx_frame_size_limit,
    output reg frame_oversize,
    output reg [3:0] link_fault_cfg
);

// ---------------------------------------------------------------
// Build options
// ---------------------------------------------------------------
localparam [0:0] HAS_100G = (IS_100G != 0) ? 1'b1 : 1'b0;
localparam [0:0] HAS_IDLE = (DEFICIT_IDLE_EN != 0) ? 1'b1 : 1'b0;
localparam [0:0] HAS_STATS = (TX_STATS_EN != 0) ? 1'b1 : 1'b0;
localparam [0:0] HAS_FAULT = (LINK_FAULT_EN != 0) ? 1'b1 : 1'b0;
localparam [7:0] IDLE_RST = HAS_100G ? `TMC_IDLE_RST_100G : `TMC_IDLE_RST_40G;

// ---------------------------------------------------------------
// Storage
// ---------------------------------------------------------------
reg [31:0] scratch_r;
reg [31:0] scratch_nxt;
reg [7:0] idle_r;
reg [7:0] idle_nxt;
reg [15:0] limit_r;
reg [15:0] limit_nxt;
reg [3:0] fault_r;
reg [3:0] fault_nxt;
reg [63:0] oversize_cnt_r;
reg [63:0] oversize_cnt_nxt;
reg oversize_nxt;
reg [31:0] rdata_nxt;

// ---------------------------------------------------------------
// Helper functions
// ---------------------------------------------------------------
function addr_hit;
    input [15:0] addr;
    input [15:0] offset;
    begin
        addr_hit = (addr == offset) ? 1'b1 : 1'b0;
    end
endfunction

function [31:0] gate_word;
    input en;
    input [31:0] word;
    begin
        gate_word = en ? word : 32'h00000000;
    end
endfunction

function [31:0] ext_byte;
    input [7:0] value;
    begin
        ext_byte = {24'h000000, value};
    end
endfunction

function [31:0] ext_half;
    input [15:0] value;
    begin
        ext_half = {16'h0000, value};
    end
endfunction

function [31:0] ext_nibble;
    input [3:0] value;
    begin
        ext_nibble = {28'h0000000, value};
    end
endfunction

function longer_than;
    input [15:0] len;
    input [15:0] limit;
    begin
        longer_than = (len > limit) ? 1'b1 : 1'b0;
    end
endfunction

function [63:0] inc64;
    input [63:0] value;
    begin
        inc64 = value + 64'h0000000000000001;
    end
endfunction

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
wire hit_revision = addr_hit(reg_addr, `TMC_OFF_REVISION);
wire hit_scratch = addr_hit(reg_addr, `TMC_OFF_SCRATCH);
wire hit_ident_first = addr_hit(reg_addr, `TMC_OFF_IDENT_FIRST);
wire hit_ident_next = addr_hit(reg_addr, `TMC_OFF_IDENT_NEXT);
wire hit_ident_final = addr_hit(reg_addr, `TMC_OFF_IDENT_FINAL);

wire hit_fault = addr_hit(reg_addr, `TMC_OFF_LINK_FAULT);
wire hit_idle = addr_hit(reg_addr, `TMC_OFF_IDLE_REMOVE);
wire hit_limit = addr_hit(reg_addr, `TMC_OFF_FRAME_LIMIT);

wire hit_count_lo = addr_hit(reg_addr, `TMC_OFF_OVERSIZE_LO);
wire hit_count_hi = addr_hit(reg_addr, `TMC_OFF_OVERSIZE_HI);

// ---------------------------------------------------------------
// Write enables, none for read-only words
// ---------------------------------------------------------------
wire wr_scratch = reg_write && hit_scratch;
wire wr_idle = reg_write && hit_idle && HAS_IDLE;
wire wr_limit = reg_write && hit_limit;
wire wr_fault = reg_write && hit_fault && HAS_FAULT;

// ---------------------------------------------------------------
// Frame classification
// ---------------------------------------------------------------
wire frame_over = frame_done && longer_than(frame_len, limit_r);

// ---------------------------------------------------------------
// Readback words
// ---------------------------------------------------------------
wire [31:0] word_revision = REVISION_VALUE;
wire [31:0] word_scratch = scratch_r;
wire [31:0] word_ident_first = IDENT_VALUE[95:64];
wire [31:0] word_ident_next = IDENT_VALUE[63:32];
wire [31:0] word_ident_final = IDENT_VALUE[31:0];
wire [31:0] word_fault = gate_word(HAS_FAULT, ext_nibble(fault_r));
wire [31:0] word_idle = gate_word(HAS_IDLE, ext_byte(idle_r));
wire [31:0] word_limit = ext_half(limit_r);
wire [31:0] word_count_lo = gate_word(HAS_STATS, oversize_cnt_r[31:0]);
wire [31:0] word_count_hi = gate_word(HAS_STATS, oversize_cnt_r[63:32]);

// ---------------------------------------------------------------
// Next values
// ---------------------------------------------------------------
always @* begin
    if (wr_scratch) begin
        scratch_nxt = reg_wdata;
    end else begin
        scratch_nxt = scratch_r;
    end
end

always @* begin
    if (wr_idle) begin
        idle_nxt = reg_wdata[7:0];
    end else begin
        idle_nxt = idle_r;
    end
end

always @* begin
    if (wr_limit) begin
        limit_nxt = reg_wdata[15:0];
    end else begin
        limit_nxt = limit_r;
    end
end

always @* begin
    if (wr_fault) begin
        fault_nxt = reg_wdata[3:0];
    end else begin
        fault_nxt = fault_r;
    end
end

always @* begin
    if (frame_over && HAS_STATS) begin
        oversize_cnt_nxt = inc64(oversize_cnt_r);
    end else begin
        oversize_cnt_nxt = oversize_cnt_r;
    end
end

always @* begin
    oversize_nxt = frame_over;
end

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
always @(posedge mclk) begin
    if (!reset_n) begin
        scratch_r <= `TMC_SCRATCH_RST;
    end else begin
        scratch_r <= scratch_nxt;
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        idle_r <= IDLE_RST;
    end else begin
        idle_r <= idle_nxt;
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        limit_r <= `TMC_FRAME_LIMIT_RST;
    end else begin
        limit_r <= limit_nxt;
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        fault_r <= 4'h0;
    end else begin
        fault_r <= fault_nxt;
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        oversize_cnt_r <= 64'h0000000000000000;
    end else begin
        oversize_cnt_r <= oversize_cnt_nxt;
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        frame_oversize <= 1'b0;
    end else begin
        frame_oversize <= oversize_nxt;
    end
end

// ---------------------------------------------------------------
// Outputs to the transmit datapath
// ---------------------------------------------------------------
always @* begin
    if (HAS_IDLE) begin
        idle_column_removal_count = idle_r;
    end else begin
        idle_column_removal_count = 8'h00;
    end
end

always @* begin
    tx_frame_size_limit = limit_r;
end

always @* begin
    if (HAS_FAULT) begin
        link_fault_cfg = fault_r;
    end else begin
        link_fault_cfg = 4'h0;
    end
end

// ---------------------------------------------------------------
// Read side
// ---------------------------------------------------------------
always @* begin
    rdata_nxt = 32'h00000000;
    case (1'b1)
        hit_revision: begin
            rdata_nxt = word_revision;
        end
        hit_scratch: begin
            rdata_nxt = word_scratch;
        end
        hit_ident_first: begin
            rdata_nxt = word_ident_first;
        end
        hit_ident_next: begin
            rdata_nxt = word_ident_next;
        end
        hit_ident_final: begin
            rdata_nxt = word_ident_final;
        end
        hit_fault: begin
            rdata_nxt = word_fault;
        end
        hit_idle: begin
            rdata_nxt = word_idle;
        end
        hit_limit: begin
            rdata_nxt = word_limit;
        end
        hit_count_lo: begin
            rdata_nxt = word_count_lo;
        end
        hit_count_hi: begin
            rdata_nxt = word_count_hi;
        end
        default: begin
            rdata_nxt = 32'h00000000;
        end
    endcase
end

always @(posedge mclk) begin
    if (!reset_n) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
        reg_rdata <= rdata_nxt;
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule // tmc_tx_mac_config_regs

// *** sim/tmc_chk_sva.sv ***
`timescale 1ns/10ps
module tmc_chk (
    input wire mclk,
    input wire reset_n,
    input wire reg_write,
    input wire reg_read,
    input wire frame_done,
    input wire frame_oversize,
    input wire [15:0] reg_addr,
    input wire [15:0] frame_len,
    input wire [15:0] tx_frame_size_limit,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(a); reg_read && reg_addr == a; endsequence
    sequence s_wr(a); reg_write && reg_addr == a; endsequence
    sequence s_scr; s_wr(16'h401) ##1 s_rd(16'h401); endsequence
    a_scr_rd: assert property (
        s_scr |=> reg_rdata == $past(reg_wdata, 2)) else $error("scratch");
    a_rev_ro: assert property (
        s_rd(16'h400) |=> reg_rdata == 32'h10000) else $error("rev");
    a_ident_ro: assert property (
        s_rd(16'h402) |=> reg_rdata == 32'h746D635F) else $error("id");
    a_lim_wr: assert property (
        s_wr(16'h407) |=> tx_frame_size_limit == $past(reg_wdata[15:0])) else $error("lim");
    a_lim_rd: assert property (
        s_rd(16'h407) |=> reg_rdata == {16'h0, tx_frame_size_limit}) else $error("lim rd");
    a_over_set: assert property (
        frame_done |=> frame_oversize == $past(frame_len > tx_frame_size_limit))
        else $error("over");
    a_over_idle: assert property (
        !frame_done |=> !frame_oversize) else $error("stray");
    a_rst_lim: assert property (
        $rose(reset_n) |-> tx_frame_size_limit == 16'h2580) else $error("rst");
endmodule // tmc_chk
bind tmc_tx_mac_config_regs tmc_chk u_chk (.*);

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
    logic mclk = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
    logic frame_done = 1'h0, frame_oversize;
    logic [15:0] reg_addr = 16'h0, frame_len = 16'h0, tx_frame_size_limit;
    logic [7:0] idle_column_removal_count;
    logic [3:0] link_fault_cfg;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    int error_cnt = 0, check_count = 0;
    always #50 mclk = ~mclk;
    tmc_tx_mac_config_regs dut (.*);
    task automatic chk_out(logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t output %h", $time, g);
        end
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] e);
        {reg_addr, reg_read} <= {a, 1'h1};
        @(posedge mclk) reg_read <= 1'h0;
        #1 check_count++;
        if (reg_rdata !== e) error_cnt++;
        if (reg_rdata !== e) $display("[ERR] %0t addr %h", $time, a);
        @(posedge mclk);
    endtask
    task automatic reg_chk(logic [15:0] a, logic [31:0] r, d, e);
        rd(a, r);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'h1};
        @(posedge mclk) reg_write <= 1'h0;
        rd(a, e);
    endtask
    task report_and_stop(int late);
        error_cnt += late;
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task t_regs;
        reg_chk(16'h400, 32'h10000, 32'hFFFFFFFF, 32'h10000);
        reg_chk(16'h401, 32'h0, 32'hA5C3F00F, 32'hA5C3F00F);
        reg_chk(16'h402, 32'h746D635F, 32'h0, 32'h746D635F);
        reg_chk(16'h405, 32'h0, 32'hF, 32'hF);
        reg_chk(16'h406, 32'h14, 32'h1FF, 32'hFF);
        reg_chk(16'h407, 32'h2580, 32'h64, 32'h64);
        reg_chk(16'h40F, 32'h0, 32'hF, 32'h0);
        chk_out({24'h0, idle_column_removal_count}, 32'hFF);
        chk_out({28'h0, link_fault_cfg}, 32'hF);
        chk_out({16'h0, tx_frame_size_limit}, 32'h64);
    endtask
    task t_frames;
        {frame_len, frame_done} <= {16'h64, 1'h1};
        @(posedge mclk) frame_len <= 16'h65;
        #1 chk_out({31'h0, frame_oversize}, 32'h0);
        @(posedge mclk) frame_done <= 1'h0;
        #1 chk_out({31'h0, frame_oversize}, 32'h1);
        rd(16'h408, 32'h1);
        rd(16'h409, 32'h0);
    endtask
    initial #100000 report_and_stop(1);
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'h1;
        @(posedge mclk);
        t_regs;
        t_frames;
        report_and_stop(0);
    end
endmodule // tb
